// File: hdl/meb_buffer.sv
`timescale 1ns/10ps
`default_nettype none
`include "meb_consts.svh"

module meb_buffer #(
    parameter int ADDR_W = `MEB_ADDR_W,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic first_level_trigger,
    input wire logic second_level_trigger,
    input wire meb_pkg::meb_word_type fmt_word,
    input wire logic fmt_valid,
    output meb_pkg::meb_word_type rdo_word,
    output logic rdo_valid,
    output logic read_busy
);
    localparam int LEN_W = ADDR_W - 1;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int FI_W = $clog2(FIFO_DEPTH);

    // distance-based decode shared by both protected machines
    function automatic meb_pkg::meb_ham_type ham_decode(input logic [`MEB_HAM_W-1:0] code);
        meb_pkg::meb_ham_type r;
        int d0;
        int d1;
        int d2;
        d0 = $countones(code ^ `MEB_HAM_C0);
        d1 = $countones(code ^ `MEB_HAM_C1);
        d2 = $countones(code ^ `MEB_HAM_C2);
        r = '{idx: 2'h0, err: 1'b0, abort: 1'b0};
        if (d0 <= 1) begin
            r.err = (d0 == 1);
        end else if (d1 <= 1) begin
            r.idx = 2'h1;
            r.err = (d1 == 1);
        end else if (d2 <= 1) begin
            r.idx = 2'h2;
            r.err = (d2 == 1);
        end else begin
            r.abort = 1'b1;
        end
        return r;
    endfunction

    function automatic logic [`MEB_HAM_W-1:0] ham_encode(input logic [1:0] idx);
        logic [`MEB_HAM_W-1:0] c;
        c = `MEB_HAM_C0;
        if (idx == 2'h1) begin
            c = `MEB_HAM_C1;
        end else if (idx == 2'h2) begin
            c = `MEB_HAM_C2;
        end
        return c;
    endfunction

    // 4-buffer mode steps by two so the pointer stays the address MSBs
    function automatic logic [`MEB_PTR_W-1:0] ptr_step(input logic [`MEB_PTR_W-1:0] p,
                                                       input logic eight);
        return eight ? p + 3'h1 : p + 3'h2;
    endfunction

    function automatic logic [ADDR_W-1:0] mem_addr(input logic [`MEB_PTR_W-1:0] p,
                                                   input logic [LEN_W-1:0] cnt);
        logic [ADDR_W-1:0] base;
        base = {p, {(ADDR_W-`MEB_PTR_W){1'b0}}};
        return base + ADDR_W'(cnt);
    endfunction

    // trigger pins: two flops before use, third for edge detection
    logic l1_s1, l1_s2, l1_s3, l2_s1, l2_s2, l2_s3;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            {l1_s1, l1_s2, l1_s3} <= 3'h0;
            {l2_s1, l2_s2, l2_s3} <= 3'h0;
        end else begin
            {l1_s1, l1_s2, l1_s3} <= {first_level_trigger, l1_s1, l1_s2};
            {l2_s1, l2_s2, l2_s3} <= {second_level_trigger, l2_s1, l2_s2};
        end
    end
    wire logic l1_evt = l1_s2 & ~l1_s3;
    wire logic l2_evt = l2_s2 & ~l2_s3;

    // registers and state
    logic eight_buffers;
    logic [`MEB_ST_W-1:0] status;
    logic [FI_W-1:0] len_sel;
    logic [`MEB_PTR_W-1:0] read_buffer_pointer, write_buffer_pointer;
    logic [LEN_W-1:0] wr_cnt, rd_cnt, event_word_counter;
    logic [`MEB_HAM_W-1:0] mem_code, if_code;
    logic [LEN_W-1:0] len_fifo [0:FIFO_DEPTH-1];
    logic [FI_W-1:0] fifo_head, fifo_tail;
    logic [FI_W:0] fifo_count;
    logic [`MEB_WORD_W-1:0] mem [0:DEPTH-1];

    // apb decode
    wire logic apb_setup = psel & ~penable;
    wire logic apb_take = psel & penable & pready;
    wire logic wr_take = apb_take & pwrite;
    wire logic hit_cfg = paddr == `MEB_REG_CONFIG;
    wire logic hit_cmd = paddr == `MEB_REG_COMMAND;
    wire logic hit_st = paddr == `MEB_REG_STATUS;
    wire logic hit_ptr = paddr == `MEB_REG_POINTERS;
    wire logic hit_len = paddr == `MEB_REG_EVENT_LEN;
    wire logic hit_wc = paddr == `MEB_REG_WORD_COUNT;
    wire logic hit_sel = paddr == `MEB_REG_LEN_SEL;
    wire logic hit_any = hit_cfg | hit_cmd | hit_st | hit_ptr | hit_len | hit_wc | hit_sel;
    wire logic cmd_readout = wr_take & hit_cmd & pwdata[`MEB_CMD_READOUT];
    wire logic cmd_advance = wr_take & hit_cmd & pwdata[`MEB_CMD_ADVANCE];

    // buffer bookkeeping
    wire logic [LEN_W-1:0] buf_words = eight_buffers ?
        LEN_W'(1 << (ADDR_W - 3)) : LEN_W'(1 << (ADDR_W - 2));
    wire logic [`MEB_PTR_W:0] nbuf = eight_buffers ? 4'h8 : 4'h4;
    wire logic fifo_empty = fifo_count == '0;
    // both sides widened on purpose, so no empty replication is needed
    wire logic bufs_full = (32'(fifo_count) >= 32'(nbuf))
        || (fifo_count == (FI_W+1)'(FIFO_DEPTH));
    wire logic [LEN_W-1:0] head_len = len_fifo[fifo_head];
    // output mux: any queued length selected relative to the oldest
    wire logic [FI_W-1:0] sel_idx = fifo_head + len_sel;
    wire logic [LEN_W-1:0] sel_len = len_fifo[sel_idx];
    // entries beyond the queue are stale or never written, so they read as zero
    wire logic sel_valid = {1'b0, len_sel} < fifo_count;

    // memory manager machine, decoded from its protected code
    wire meb_pkg::meb_ham_type mem_dec = ham_decode(mem_code);
    meb_pkg::meb_mem_state_type mem_state;
    always_comb begin
        unique case (mem_dec.idx)
            2'h1: mem_state = meb_pkg::MEM_STORE;
            2'h2: mem_state = meb_pkg::MEM_HOLD;
            default: mem_state = meb_pkg::MEM_IDLE;
        endcase
        if (mem_dec.abort) begin
            mem_state = meb_pkg::MEM_IDLE;
        end
    end

    meb_pkg::meb_mem_state_type next_mem_state;
    logic l1_refused, l2_push, word_store, word_last;
    // a one-bit image takes the same transition as its code
    always_comb begin
        next_mem_state = mem_state;
        l1_refused = 1'b0;
        l2_push = 1'b0;
        word_store = 1'b0;
        word_last = 1'b0;
        unique case (mem_state)
            meb_pkg::MEM_IDLE: begin
                if (l1_evt && !bufs_full) begin
                    next_mem_state = meb_pkg::MEM_STORE;
                end else if (l1_evt) begin
                    l1_refused = 1'b1;
                end
            end
            meb_pkg::MEM_STORE: begin
                if (l1_evt) begin
                    next_mem_state = meb_pkg::MEM_STORE;
                end else if (fmt_valid) begin
                    word_store = wr_cnt < buf_words;
                    word_last = fmt_word.last;
                    if (fmt_word.last) begin
                        next_mem_state = meb_pkg::MEM_HOLD;
                    end
                end
            end
            meb_pkg::MEM_HOLD: begin
                // an unvalidated event is simply overwritten by the next one
                if (l1_evt) begin
                    next_mem_state = meb_pkg::MEM_STORE;
                end else if (l2_evt) begin
                    l2_push = 1'b1;
                    next_mem_state = meb_pkg::MEM_IDLE;
                end
            end
        endcase
    end
    wire logic [1:0] next_mem_idx = next_mem_state == meb_pkg::MEM_STORE ? 2'h1 :
        next_mem_state == meb_pkg::MEM_HOLD ? 2'h2 : 2'h0;

    // interface machine
    wire meb_pkg::meb_ham_type if_dec = ham_decode(if_code);
    wire logic if_abort = if_dec.abort | (if_dec.idx == 2'h2);
    meb_pkg::meb_if_state_type if_state;
    assign if_state = (!if_abort && if_dec.idx == 2'h1) ?
        meb_pkg::IF_READ : meb_pkg::IF_IDLE;

    meb_pkg::meb_if_state_type next_if_state;
    logic rd_start, rd_word, rd_done, rd_pop;
    always_comb begin
        next_if_state = if_state;
        rd_start = 1'b0;
        rd_word = 1'b0;
        rd_done = 1'b0;
        rd_pop = 1'b0;
        unique case (if_state)
            meb_pkg::IF_IDLE: begin
                if (cmd_advance && !fifo_empty) begin
                    rd_pop = 1'b1;
                end else if (cmd_readout && !fifo_empty && head_len != '0) begin
                    rd_start = 1'b1;
                    next_if_state = meb_pkg::IF_READ;
                end
            end
            meb_pkg::IF_READ: begin
                rd_word = 1'b1;
                rd_done = rd_cnt == head_len - LEN_W'(1);
                if (rd_done) begin
                    next_if_state = meb_pkg::IF_IDLE;
                end
            end
        endcase
    end

    // protected state registers are rewritten with clean codes every edge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mem_code <= `MEB_HAM_C0;
            if_code <= `MEB_HAM_C0;
        end else begin
            mem_code <= ham_encode(next_mem_idx);
            if_code <= ham_encode(next_if_state == meb_pkg::IF_READ ? 2'h1 : 2'h0);
        end
    end

    // write side counters and pointer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_cnt <= '0;
            event_word_counter <= '0;
            write_buffer_pointer <= '0;
        end else begin
            if (l1_evt && next_mem_state == meb_pkg::MEM_STORE) begin
                wr_cnt <= '0;
            end else if (word_store) begin
                wr_cnt <= wr_cnt + LEN_W'(1);
            end
            if (word_last) begin
                event_word_counter <= word_store ? wr_cnt + LEN_W'(1) : wr_cnt;
            end
            if (l2_push) begin
                write_buffer_pointer <= ptr_step(write_buffer_pointer, eight_buffers);
            end
        end
    end

    // storage needs no reset; only validated contents are ever read
    always_ff @(posedge mclk) begin
        if (word_store) begin
            mem[mem_addr(write_buffer_pointer, wr_cnt)] <= fmt_word.data;
        end
    end

    // event length fifo, pushed only on validation
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fifo_head <= '0;
            fifo_tail <= '0;
            fifo_count <= '0;
            read_buffer_pointer <= '0;
        end else begin
            if (l2_push) begin
                fifo_tail <= fifo_tail + FI_W'(1);
            end
            if (rd_pop) begin
                fifo_head <= fifo_head + FI_W'(1);
                read_buffer_pointer <= ptr_step(read_buffer_pointer, eight_buffers);
            end
            if (l2_push && !rd_pop) begin
                fifo_count <= fifo_count + (FI_W+1)'(1);
            end else if (rd_pop && !l2_push) begin
                fifo_count <= fifo_count - (FI_W+1)'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (l2_push) begin
            len_fifo[fifo_tail] <= event_word_counter;
        end
    end

    // readout stream, one word per cycle while reading
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rd_cnt <= '0;
            rdo_word <= '0;
            rdo_valid <= 1'b0;
            read_busy <= 1'b0;
        end else begin
            if (rd_start) begin
                rd_cnt <= '0;
            end else if (rd_word) begin
                rd_cnt <= rd_cnt + LEN_W'(1);
            end
            rdo_valid <= rd_word;
            rdo_word.data <= rd_word ? mem[mem_addr(read_buffer_pointer, rd_cnt)] : '0;
            rdo_word.last <= rd_done;
            read_busy <= next_if_state == meb_pkg::IF_READ;
        end
    end

    // sticky status: hardware set wins over a write-one clear
    wire logic [`MEB_ST_W-1:0] st_set = {
        l1_refused,
        if_abort,
        if_dec.err & ~if_abort,
        mem_dec.abort,
        mem_dec.err
    };
    wire logic [`MEB_ST_W-1:0] st_clr = (wr_take && hit_st) ? pwdata[`MEB_ST_W-1:0] : '0;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status <= `MEB_ST_RESET;
            eight_buffers <= `MEB_CFG_RESET;
            len_sel <= '0;
        end else begin
            status <= (status & ~st_clr) | st_set;
            if (wr_take && hit_cfg) begin
                eight_buffers <= pwdata[`MEB_CFG_EIGHT];
            end
            if (wr_take && hit_sel) begin
                len_sel <= pwdata[FI_W-1:0];
            end
        end
    end

    // read data mux, captured in the setup cycle
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (hit_cfg) begin
            rd_mux[`MEB_CFG_EIGHT] = eight_buffers;
        end else if (hit_st) begin
            rd_mux[`MEB_ST_W-1:0] = status;
        end else if (hit_ptr) begin
            rd_mux[`MEB_PTR_W-1:0] = write_buffer_pointer;
            rd_mux[`MEB_PTR_RD_LSB +: `MEB_PTR_W] = read_buffer_pointer;
        end else if (hit_len) begin
            rd_mux[LEN_W-1:0] = sel_valid ? sel_len : '0;
        end else if (hit_wc) begin
            rd_mux[LEN_W-1:0] = event_word_counter;
        end else if (hit_sel) begin
            rd_mux[FI_W-1:0] = len_sel;
        end
    end

    // ready rises for exactly the first access cycle: no wait states
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~hit_any;
            prdata <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
        end
    end
endmodule
`default_nettype wire

// File: inc/meb_consts.svh
// How it works
// - read and write buffer pointers give each buffer's first memory address.
// - a stored event's length in 40-bit words is held in the word counter.
// - every accepted first-level trigger clears the write address counter.
// - event lengths enter a circular FIFO only on a second-level trigger.
// - an output mux makes stored event lengths readable from outside.
// - the memory splits into 4 or 8 equal buffers, chosen by configuration.
// - the pointer forms the three address MSBs; counters form the rest.
// - triggered data is stored, then kept only once validated by second level.
// - the readout command streams out the oldest validated buffer.
// - readout keeps the buffer; the advance command moves the read pointer.
// - advance also discards a validated event that was never read.
// - both memory and interface machines use single-error-correcting codes.
// - valid state codes stay at least three bits apart.
// - a code one bit from a valid state acts as that state.
// - codes two bits from every valid state are abort codes.
// - a one-bit image takes its normal transition, else restores its state.
// - correction is done by the next rising clock edge.
// - an abort code drops the sequence and returns to idle.
// - moving into a one-bit image sets a status error bit.
// - moving into an abort code sets a status abort bit.
`ifndef MEB_CONSTS_SVH
`define MEB_CONSTS_SVH

`define MEB_WORD_W 40
`define MEB_PTR_W 3
`define MEB_ADDR_W 6

// state codes, pairwise at least three bits apart
`define MEB_HAM_W 5
`define MEB_HAM_C0 5'h00
`define MEB_HAM_C1 5'h07
`define MEB_HAM_C2 5'h19

// register byte offsets
`define MEB_REG_CONFIG 8'h00
`define MEB_REG_COMMAND 8'h04
`define MEB_REG_STATUS 8'h08
`define MEB_REG_POINTERS 8'h0C
`define MEB_REG_EVENT_LEN 8'h10
`define MEB_REG_WORD_COUNT 8'h14
`define MEB_REG_LEN_SEL 8'h18

// field positions
`define MEB_CFG_EIGHT 0
`define MEB_CMD_READOUT 0
`define MEB_CMD_ADVANCE 1
`define MEB_ST_MEM_ERR 0
`define MEB_ST_MEM_ABORT 1
`define MEB_ST_IF_ERR 2
`define MEB_ST_IF_ABORT 3
`define MEB_ST_OVERFLOW 4
`define MEB_ST_W 5
`define MEB_PTR_RD_LSB 4

// reset values
`define MEB_CFG_RESET 1'b0
`define MEB_ST_RESET 5'h00

`endif

// File: inc/meb_pkg.sv
`include "meb_consts.svh"

package meb_pkg;
    typedef enum logic [2:0] {
        MEM_IDLE = 3'b001,
        MEM_STORE = 3'b010,
        MEM_HOLD = 3'b100
    } meb_mem_state_type;

    typedef enum logic [1:0] {
        IF_IDLE = 2'b01,
        IF_READ = 2'b10
    } meb_if_state_type;

    // decoded protected state: nearest code index and flags
    typedef struct packed {
        logic [1:0] idx;
        logic err;
        logic abort;
    } meb_ham_type;

    typedef struct packed {
        logic [`MEB_WORD_W-1:0] data;
        logic last;
    } meb_word_type;
endpackage

// File: verification/meb_front_end.sv
`timescale 1ns/10ps
`default_nettype none
module meb_front_end (
    input wire logic mclk,
    output logic first_level_trigger,
    output logic second_level_trigger,
    output meb_pkg::meb_word_type fmt_word,
    output logic fmt_valid
);
    initial begin
        first_level_trigger = 1'b0;
        second_level_trigger = 1'b0;
        fmt_word = '0;
        fmt_valid = 1'b0;
    end
    // one event: trigger, words with last on the final one, then validation
    task automatic send_event(input int len, input logic [7:0] id, input logic validate);
        int i;
        @(posedge mclk);
        first_level_trigger <= 1'b1;
        @(posedge mclk);
        first_level_trigger <= 1'b0;
        repeat (4) @(posedge mclk);
        for (i = 0; i < len; i++) begin
            fmt_word <= {id, 32'(i), 1'(i == len - 1)};
            fmt_valid <= 1'b1;
            @(posedge mclk);
        end
        fmt_valid <= 1'b0;
        fmt_word <= ~fmt_word; // idle data must not echo the last word
        repeat (2) @(posedge mclk);
        second_level_trigger <= validate;
        @(posedge mclk);
        second_level_trigger <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// File: verification/meb_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module meb_monitor (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire meb_pkg::meb_word_type rdo_word,
    input wire logic rdo_valid,
    input wire logic read_busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // register access: zero wait states, so a slow answer is a fault
    pready_setup_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without answer");
    unmapped_err_a: assert property (psel && !penable |=>
        pslverr == ($past(paddr) > 8'h18 || $past(paddr[1:0]) != 2'h0))
        else $error("error flag wrong for address");
    prdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    // readout stream: starts one cycle after busy, unbroken until last
    first_word_a: assert property ($rose(read_busy) |=> rdo_valid)
        else $error("first word late");
    words_contig_a: assert property (rdo_valid && !rdo_word.last |=> rdo_valid)
        else $error("gap in readout");
    busy_ends_a: assert property (rdo_valid && rdo_word.last |=> !read_busy && !rdo_valid)
        else $error("readout ran past last");
    valid_busy_a: assert property (rdo_valid |-> read_busy || $past(read_busy))
        else $error("word outside readout");
endmodule
bind meb_buffer meb_monitor i_meb_monitor (.mclk(mclk), .nrst(nrst), .paddr(paddr),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rdo_word(rdo_word), .rdo_valid(rdo_valid), .read_busy(read_busy));
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "meb_consts.svh"
module testbench;
    typedef struct packed {logic [7:0] addr; logic [31:0] exp; logic err;} meb_row_type;
    localparam meb_row_type rows [7] = '{'{8'h00, 32'h0, 1'b0}, '{8'h08, 32'h0, 1'b0},
        '{8'h0C, 32'h0, 1'b0}, '{8'h10, 32'h0, 1'b0}, '{8'h14, 32'h0, 1'b0},
        '{8'h18, 32'h0, 1'b0}, '{8'h1C, 32'h0, 1'b1}};
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr, er;
    logic l1, l2, fmt_valid, rdo_valid, read_busy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    meb_pkg::meb_word_type fmt_word, rdo_word;
    int errors, n_compared, cycles, k;
    meb_buffer i_meb_buffer (.mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .first_level_trigger(l1),
        .second_level_trigger(l2), .fmt_word(fmt_word), .fmt_valid(fmt_valid),
        .rdo_word(rdo_word), .rdo_valid(rdo_valid), .read_busy(read_busy));
    meb_front_end i_meb_front_end (.mclk(mclk), .first_level_trigger(l1),
        .second_level_trigger(l2), .fmt_word(fmt_word), .fmt_valid(fmt_valid));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [40:0] got, input logic [40:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            errors++;
        end
    endtask
    // one transfer, held until pready is seen high at a rising edge
    task automatic apb(input logic [7:0] addr, input logic wr, input logic [31:0] wdata);
        int t;
        t = 0;
        @(posedge mclk);
        paddr <= addr;
        pwrite <= wr;
        pwdata <= wdata;
        psel <= 1'b1;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (pready !== 1'b1) begin
            errors++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        apb(addr, 1'b0, 32'h0);
        chk(rd, exp);
    endtask
    // start a readout and compare every streamed word
    task automatic read_event(input int len, input logic [7:0] id);
        int i, t;
        i = 0;
        t = 0;
        apb(`MEB_REG_COMMAND, 1'b1, 32'h1);
        while (i < len && t < 100) begin
            @(posedge mclk);
            t++;
            if (rdo_valid === 1'b1) begin
                chk(rdo_word, {id, 32'(i), 1'(i == len - 1)});
                i++;
            end
        end
        chk(41'(i), 41'(len));
    endtask
    // hang guard: whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            results();
        end
    end
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        n_compared = 0;
        cycles = 0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        foreach (rows[r]) begin
            apb(rows[r].addr, 1'b0, 32'h0);
            chk(rd, rows[r].exp);
            chk(er, rows[r].err);
        end
        // four-buffer mode: fill all buffers, pointer steps by two and wraps
        for (k = 0; k < 4; k++) begin
            i_meb_front_end.send_event(k + 1, 8'(k), 1'b1);
            rd_chk(`MEB_REG_WORD_COUNT, 32'(k + 1));
            rd_chk(`MEB_REG_POINTERS, 32'((2 * k + 2) % 8));
        end
        for (k = 0; k < 4; k++) begin
            apb(`MEB_REG_LEN_SEL, 1'b1, 32'(k));
            rd_chk(`MEB_REG_EVENT_LEN, 32'(k + 1));
        end
        // a trigger with every buffer full must not overwrite the oldest event
        i_meb_front_end.send_event(1, 8'h09, 1'b0);
        rd_chk(`MEB_REG_STATUS, 32'h10);
        apb(`MEB_REG_STATUS, 1'b1, 32'h1F);
        rd_chk(`MEB_REG_STATUS, 32'h0);
        for (k = 0; k < 4; k++) begin
            read_event(k + 1, 8'(k));
            rd_chk(`MEB_REG_POINTERS, 32'(2 * k) << 4);
            apb(`MEB_REG_COMMAND, 1'b1, 32'h2);
            rd_chk(`MEB_REG_POINTERS, 32'((2 * k + 2) % 8) << 4);
        end
        // eight-buffer mode: discard an unread event, then store and read the next one in buffer 1
        apb(`MEB_REG_CONFIG, 1'b1, 32'h1);
        i_meb_front_end.send_event(2, 8'h20, 1'b1);
        rd_chk(`MEB_REG_POINTERS, 32'h01);
        apb(`MEB_REG_COMMAND, 1'b1, 32'h2);
        rd_chk(`MEB_REG_POINTERS, 32'h11);
        i_meb_front_end.send_event(3, 8'h30, 1'b1);
        read_event(3, 8'h30);
        rd_chk(`MEB_REG_STATUS, 32'h0);
        // mid-run reset: pointers, mode and counters return to idle values
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        chk(read_busy, 1'b0);
        rd_chk(`MEB_REG_POINTERS, 32'h0);
        rd_chk(`MEB_REG_CONFIG, 32'h0);
        rd_chk(`MEB_REG_WORD_COUNT, 32'h0);
        rd_chk(`MEB_REG_EVENT_LEN, 32'h0);
        i_meb_front_end.send_event(1, 8'h40, 1'b1);
        read_event(1, 8'h40);
        results();
    end
endmodule
`default_nettype wire
